/* twm_pkg.sv */
// constants, states and carrier types of the two-wire bus master
package twm_pkg;
    // system clock and bus free time after a stop
    localparam int CLK_NS = 5;
    localparam int T_FREE_NS = 4700;
    localparam int FREE_CYC = (T_FREE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [9:0] FREE_CNT = 10'(FREE_CYC);
    // register byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STAT = 4'h4;
    localparam logic [3:0] OFS_DATA = 4'h8;
    localparam logic [3:0] OFS_DIV = 4'hc;
    // control register bits
    localparam int CB_START = 0;
    localparam int CB_STOP = 1;
    localparam int CB_IRQ = 2;
    localparam int CB_SAS = 3;
    localparam int CB_NACK = 4;
    // status register bits
    localparam int SB_ERR = 0;
    localparam int SB_DSR = 1;
    localparam int SB_REF = 2;
    localparam int SB_SAS = 3;
    localparam int SB_OWN = 4;
    localparam int SB_BUSY = 5;
    // reset value of the half period in clock cycles (200 kHz)
    localparam logic [9:0] DIV_RST = 10'h1f4;
    // master sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_WAIT, ST_START, ST_HOLD, ST_LOW, ST_HIGH, ST_STOP
    } twm_state_t;
    // the two bus lines
    typedef struct packed {
        logic scl;
        logic sda;
    } twm_line_t;
    // sticky flags, bit 0 upward: err, dsr, refused, sas, owner
    typedef struct packed {
        logic owner;
        logic sas;
        logic refused;
        logic dsr;
        logic err;
    } twm_flags_t;
endpackage

/* twm_master.sv */
// two-wire bus master: start acquisition, address/data bytes, bus monitor
// How it works
// (R01) data changes only while clock low
// (R02) data change in clock high aborts transfer
// (R03) start/stop are data edges with clock high
// (R04) bus busy from start until after stop
// (R05) bytes go msb first, then acknowledge
// (R06) ninth clock is ack; transmitter releases data
// (R07) receiving master leaves data high on last
// (R08) busy or failing receiver answers with nack
// (R09) seven address bits then direction, 1=read
// (R10) slave holding clock low stalls the master
// (R11) all-zero address is a broadcast call
// (R12) data mismatch while sending aborts the master
// (R13) clock period follows slowest, high shortest
// (R14) lost address arbitration drops to slave mode; here the master clears owner and goes idle, it has no slave mode
// (R15) start request waits free bus, then stalls
// (R16) early clock low sets error else owner
// (R17) error or service flag raises enabled interrupt
// (R18) data write sends address, ack into refused
// (R19) conflict during address aborts, error, not owner
// (R20) stall after start flag and clock held
// (R21) transmit address done sets service request
// (R22) read address done receives first byte
// (R23) lines are open drain, pull low only
// (R24) stray start/stop mid byte is error
// (R25) clock period from programmed half period
//
// Our own choices: the Avalon-MM slave port and the register offsets.
module twm_master (
    input wire logic clk,                       // system clock
    input wire logic reset_n,                   // synchronous reset
    input wire logic [3:0] address,             // byte address
    input wire logic read,                      // read request
    input wire logic write,                     // write request
    input wire logic [31:0] writedata,          // write data
    output logic [31:0] readdata,               // read data
    output logic waitrequest,                   // stall of the bus access
    input wire twm_pkg::twm_line_t line_in,     // sampled bus lines
    output twm_pkg::twm_line_t line_out,        // driven level, always low
    output twm_pkg::twm_line_t line_oe,         // high while pulling low
    output logic irq                            // interrupt request
);
    import twm_pkg::*;

    // ==========================================
    // line synchronisers and condition detection
    twm_line_t line_q1;
    twm_line_t line_q2;
    twm_line_t line_q3;
    logic scl_s;
    logic sda_s;
    logic start_det;
    logic stop_det;

    // two stages before any logic, third for edges
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            line_q1 <= 2'h3;
            line_q2 <= 2'h3;
            line_q3 <= 2'h3;
        end else begin
            line_q1 <= line_in;
            line_q2 <= line_q1;
            line_q3 <= line_q2;
        end
    end

    assign scl_s = line_q2.scl;
    assign sda_s = line_q2.sda;
    // start: data falls with clock high; stop: data rises
    assign start_det = scl_s && line_q3.scl && line_q3.sda && !sda_s; // R03
    assign stop_det = scl_s && line_q3.scl && !line_q3.sda && sda_s; // R03

    // ==========================================
    // avalon slave handshake, one wait state
    logic done;
    logic wr_go;
    logic rd_go;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            done <= 1'b0;
        end else begin
            done <= (read || write) && !done;
        end
    end

    assign waitrequest = (read || write) && !done;
    assign wr_go = write && done;
    assign rd_go = read && done;

    // ==========================================
    // registers and state
    twm_state_t state;
    twm_flags_t fl;
    logic busy;
    logic [9:0] free_cnt;
    logic start_req;
    logic stop_req;
    logic irq_allow;
    logic sas_on;
    logic nack_last;
    logic [9:0] div_half;
    logic [7:0] data_reg;
    logic [7:0] sh;
    logic [3:0] bit_n;
    logic [9:0] cnt;
    logic seen;
    logic samp;
    logic rx_mode;
    logic dir_rd;
    logic addr_phase;
    logic wait_sas;
    logic scl_drv;
    logic sda_drv;
    logic want_low;
    logic lose;
    logic stray;

    // bus busy from start until the free time after a stop
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            busy <= 1'b0;
            free_cnt <= 10'h000;
        end else begin
            if (wr_go && address == OFS_STAT && writedata[SB_BUSY]) begin
                busy <= 1'b0;
            end
            if (start_det) begin
                busy <= 1'b1; // R04
                free_cnt <= 10'h000;
            end else if (stop_det) begin
                free_cnt <= FREE_CNT; // R04
            end else if (free_cnt != 10'h000) begin
                free_cnt <= free_cnt - 10'h001;
                if (free_cnt == 10'h001) begin
                    busy <= 1'b0;
                end
            end
        end
    end

    // level wanted on data: msb first, ack in ninth slot
    assign want_low = (bit_n == 4'h8) ? (rx_mode && !nack_last) : (!rx_mode && !sh[7]); // R05 R06 R07
    // released data seen low while we send: lost arbitration
    assign lose = (state == ST_HIGH) && seen && bit_n != 4'h8 && !rx_mode && !sda_drv && !sda_s; // R12
    // start or stop seen inside a byte
    assign stray = (state == ST_LOW || state == ST_HIGH) && (start_det || stop_det); // R02 R24

    // ==========================================
    // sequencer, control bits and sticky flags
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            fl <= '0;
            start_req <= 1'b0;
            stop_req <= 1'b0;
            irq_allow <= 1'b0;
            sas_on <= 1'b0;
            nack_last <= 1'b0;
            div_half <= DIV_RST;
            data_reg <= 8'h00;
            sh <= 8'h00;
            bit_n <= 4'h0;
            cnt <= 10'h000;
            seen <= 1'b0;
            samp <= 1'b1;
            rx_mode <= 1'b0;
            dir_rd <= 1'b0;
            addr_phase <= 1'b0;
            wait_sas <= 1'b0;
            scl_drv <= 1'b0;
            sda_drv <= 1'b0;
        end else begin
            // software writes; hardware sets below win
            if (wr_go && address == OFS_CTRL) begin
                start_req <= writedata[CB_START];
                stop_req <= writedata[CB_STOP];
                irq_allow <= writedata[CB_IRQ];
                sas_on <= writedata[CB_SAS];
                nack_last <= writedata[CB_NACK];
            end
            if (wr_go && address == OFS_STAT) begin
                if (writedata[SB_ERR]) fl.err <= 1'b0;
                if (writedata[SB_REF]) fl.refused <= 1'b0;
                if (writedata[SB_SAS]) fl.sas <= 1'b0;
            end
            if (wr_go && address == OFS_DIV) begin
                div_half <= writedata[9:0]; // R25
            end
            case (state)
                ST_IDLE: begin
                    scl_drv <= 1'b0;
                    sda_drv <= 1'b0;
                    if (start_req) begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (!busy) begin // R15
                        state <= ST_START;
                        cnt <= div_half;
                    end
                end
                ST_START: begin
                    if (!scl_s) begin
                        fl.err <= 1'b1; // R16
                        start_req <= 1'b0;
                        sda_drv <= 1'b0;
                        state <= ST_IDLE;
                    end else if (!sda_drv) begin
                        sda_drv <= 1'b1; // R03
                    end else if (cnt != 10'h000) begin
                        cnt <= cnt - 10'h001;
                    end else begin
                        scl_drv <= 1'b1; // R15
                        fl.owner <= 1'b1; // R16
                        fl.dsr <= 1'b1; // R16
                        start_req <= 1'b0;
                        addr_phase <= 1'b1;
                        rx_mode <= 1'b0;
                        state <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    scl_drv <= 1'b1; // R15
                    if (wr_go && address == OFS_DATA) begin
                        sh <= writedata[7:0]; // R18
                        data_reg <= writedata[7:0];
                        if (addr_phase) dir_rd <= writedata[0]; // R09
                        fl.dsr <= 1'b0;
                        rx_mode <= 1'b0;
                        bit_n <= 4'h0;
                        cnt <= div_half;
                        state <= ST_LOW;
                    end else if (rd_go && address == OFS_DATA && rx_mode && fl.dsr) begin
                        fl.dsr <= 1'b0;
                        bit_n <= 4'h0;
                        cnt <= div_half;
                        state <= ST_LOW;
                    end else if (wait_sas && !fl.sas) begin
                        wait_sas <= 1'b0;
                        if (dir_rd) begin
                            rx_mode <= 1'b1;
                            bit_n <= 4'h0;
                            cnt <= div_half;
                            state <= ST_LOW;
                        end else begin
                            fl.dsr <= 1'b1;
                        end
                    end else if (stop_req) begin
                        stop_req <= 1'b0;
                        wait_sas <= 1'b0;
                        seen <= 1'b0;
                        cnt <= div_half;
                        state <= ST_STOP;
                    end
                end
                ST_LOW: begin
                    scl_drv <= 1'b1;
                    if (stray) begin
                        fl.err <= 1'b1; // R24
                        fl.owner <= 1'b0;
                        state <= ST_IDLE;
                    end else begin
                        // data moves mid low only, never near a clock edge
                        if (cnt == {1'b0, div_half[9:1]}) sda_drv <= want_low; // R01 R23
                        if (cnt != 10'h000) begin
                            cnt <= cnt - 10'h001;
                        end else begin
                            scl_drv <= 1'b0;
                            seen <= 1'b0;
                            cnt <= div_half;
                            state <= ST_HIGH;
                        end
                    end
                end
                ST_HIGH: begin
                    if (stray) begin
                        fl.err <= 1'b1; // R02
                        fl.owner <= 1'b0;
                        state <= ST_IDLE;
                    end else if (!seen) begin
                        // wait while any party holds the clock low
                        if (scl_s) begin // R10 R13
                            seen <= 1'b1;
                            samp <= sda_s; // R01
                        end
                    end else if (lose) begin
                        fl.err <= 1'b1; // R19
                        fl.owner <= 1'b0; // R14
                        sda_drv <= 1'b0;
                        state <= ST_IDLE;
                    end else if (scl_s && cnt != 10'h000) begin
                        cnt <= cnt - 10'h001;
                    end else begin
                        // high ends at count or when another master pulls low
                        scl_drv <= 1'b1; // R13
                        cnt <= div_half;
                        if (bit_n != 4'h8) begin
                            sh <= {sh[6:0], rx_mode ? samp : 1'b0}; // R05
                            bit_n <= bit_n + 4'h1;
                            state <= ST_LOW;
                        end else if (rx_mode) begin
                            data_reg <= sh;
                            fl.dsr <= 1'b1;
                            state <= ST_HOLD;
                        end else begin
                            fl.refused <= samp; // R18 R08
                            addr_phase <= 1'b0;
                            state <= ST_HOLD;
                            if (!samp && addr_phase && sas_on) begin
                                fl.sas <= 1'b1; // R20
                                wait_sas <= 1'b1;
                            end else if (!samp && addr_phase && dir_rd) begin
                                rx_mode <= 1'b1; // R22
                                bit_n <= 4'h0;
                                state <= ST_LOW;
                            end else if (!samp) begin
                                fl.dsr <= 1'b1; // R21 R11
                            end
                        end
                    end
                end
                ST_STOP: begin
                    if (!seen) begin
                        sda_drv <= 1'b1;
                        if (cnt != 10'h000) begin
                            cnt <= cnt - 10'h001;
                        end else begin
                            scl_drv <= 1'b0;
                            seen <= 1'b1;
                            cnt <= div_half;
                        end
                    end else if (scl_s) begin
                        if (cnt != 10'h000) begin
                            cnt <= cnt - 10'h001;
                        end else begin
                            sda_drv <= 1'b0; // R03
                            fl.owner <= 1'b0;
                            rx_mode <= 1'b0;
                            state <= ST_IDLE;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================
    // read data, taken one cycle before the answer
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            readdata <= 32'h0000_0000;
        end else if (read && !done) begin
            case (address)
                OFS_CTRL: readdata <= {27'h0, nack_last, sas_on, irq_allow, stop_req, start_req};
                OFS_STAT: readdata <= {26'h0, busy, fl};
                OFS_DATA: readdata <= {24'h0, data_reg};
                OFS_DIV: readdata <= {22'h0, div_half};
                default: readdata <= 32'h0000_0000;
            endcase
        end
    end
    // open drain: the output level is always low
    assign line_out = 2'h0; // R23
    assign line_oe.scl = scl_drv;
    assign line_oe.sda = sda_drv;
    assign irq = irq_allow && (fl.err || fl.dsr || fl.refused || fl.sas); // R17

    // ==========================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_req_wait;
        (read || write) && waitrequest;
    endsequence
    sequence s_answer;
        !waitrequest;
    endsequence
    a_bus_answer: assert property (s_req_wait |=> s_answer)
        else $error("access not answered after one wait state");
    a_sda_high_stable: assert property (state == ST_HIGH && $past(state) == ST_HIGH |-> $stable(sda_drv)) // R01
        else $error("data changed while clock released");
    a_start_edge: assert property (state == ST_START && $rose(sda_drv) |-> !scl_drv) // R03
        else $error("start issued with clock held low");
    a_busy_start: assert property (start_det |=> busy) // R04
        else $error("busy not set by start");
    a_ack_release: assert property (state == ST_HIGH && bit_n == 4'h8 && !rx_mode |-> !sda_drv) // R06
        else $error("transmitter kept data in ack slot");
    a_arb_loss: assert property (lose |=> fl.err && !fl.owner && state == ST_IDLE) // R12
        else $error("lost arbitration not handled");
    a_hold_clock: assert property (state == ST_HOLD && $past(state) == ST_HOLD |-> scl_drv) // R15
        else $error("clock released during stall");
    a_stray_cond: assert property (stray && !lose |=> fl.err && state == ST_IDLE) // R24
        else $error("stray condition not flagged");
    a_irq_flags: assert property (irq_allow && (fl.err || fl.dsr) |-> irq) // R17
        else $error("interrupt missing");
endmodule

/* twm_slave_model.sv */
// slave model standing on the far side of the two-wire bus
module twm_slave_model #(
    parameter logic [6:0] MY_ADDR = 7'h50 // address this slave answers
) (
    input wire logic clk,             // sampling clock
    input wire logic scl,             // clock wire level
    input wire logic sda,             // data wire level
    input wire logic [7:0] stretch,   // cycles the clock is held low after each fall
    input wire logic [7:0] tx_byte,   // byte returned on a read
    output logic scl_oe,              // high while holding the clock low
    output logic sda_oe,              // high while pulling data low
    output logic [7:0] rx_byte,       // last byte shifted in
    output logic last_ack,            // data level at the last ninth clock
    output int n_bytes,               // bytes since the last start
    output int n_stops                // stop conditions seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic scl_q, sda_q, adr, sel, rd;
    int bitn;
    int hold;
    // idle bus: both lines released
    initial begin
        {scl_q, sda_q} = 2'b11;
        {adr, sel, rd, scl_oe, sda_oe, last_ack} = '0;
        rx_byte = 8'h00;
        {bitn, hold, n_bytes, n_stops} = '0;
    end
    // bit tracking, acknowledge, read data and clock stretch
    always @(posedge clk) begin
        scl_q <= scl;
        sda_q <= sda;
        if (hold > 1) begin
            hold <= hold - 1;
        end else begin
            scl_oe <= 1'b0; // release after the stall
        end
        if (scl_q && scl && sda_q && !sda) begin // start seen
            bitn <= -1;
            n_bytes <= 0;
            {adr, sel, rd, sda_oe} <= 4'b1000;
        end else if (scl_q && scl && !sda_q && sda) begin // stop seen
            n_stops <= n_stops + 1;
            {adr, sel, sda_oe} <= 3'b000;
        end else if (!scl_q && scl) begin // sample while the clock is high
            if (bitn < 8) begin
                rx_byte <= {rx_byte[6:0], sda}; // msb first
            end else begin
                last_ack <= sda; // ninth clock
            end
        end else if (scl_q && !scl) begin // change only with the clock low
            scl_oe <= stretch != 8'h00; // hold the clock low
            hold <= int'(stretch);
            bitn <= (bitn == 8) ? 0 : bitn + 1;
            if (bitn == 7) begin
                // acknowledge own or all-zero broadcast address, or written data
                sel <= adr ? (rx_byte[7:1] == MY_ADDR || rx_byte == 8'h00) : sel;
                rd <= adr ? rx_byte[0] : rd;
                sda_oe <= adr ? (rx_byte[7:1] == MY_ADDR || rx_byte == 8'h00) : (sel && !rd);
            end else if (bitn == 8) begin
                n_bytes <= n_bytes + 1;
                adr <= 1'b0;
                sda_oe <= sel && rd && (adr || !last_ack) && !tx_byte[7]; // stop sending on nack
            end else begin
                sda_oe <= sel && rd && !adr && !tx_byte[6 - bitn];
            end
        end
    end
endmodule

/* tb_two_wire_bus_master_start.sv */
// bench of the two-wire bus master: register accesses and bus transactions
module tb_two_wire_bus_master_start;
    timeunit 1ns;
    timeprecision 1ps;
    import twm_pkg::*;
    // ==========================================
    // signals and wiring
    localparam logic [31:0] K_START = 32'h1 << CB_START, K_STOP = 32'h1 << CB_STOP, K_IRQ = 32'h1 << CB_IRQ,
        K_SAS = 32'h1 << CB_SAS, K_NACK = 32'h1 << CB_NACK, S_ERR = 32'h1 << SB_ERR, S_DSR = 32'h1 << SB_DSR,
        S_REF = 32'h1 << SB_REF, S_SAS = 32'h1 << SB_SAS, S_OWN = 32'h1 << SB_OWN, S_BUSY = 32'h1 << SB_BUSY;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic other_scl = 1'b0;
    logic other_sda = 1'b0;
    logic [7:0] stretch = 8'h00;
    logic [31:0] readdata, q;
    logic waitrequest, irq, slv_scl, slv_sda, scl_w, sda_w, last_ack;
    logic [7:0] rx_byte;
    twm_line_t line_in, line_out, line_oe;
    int n_bytes, n_stops;
    int error_cnt = 0;
    int n_compared = 0;
    // wired-and lines with pull-ups
    assign scl_w = !(line_oe.scl | slv_scl | other_scl);
    assign sda_w = !(line_oe.sda | slv_sda | other_sda);
    assign line_in = '{scl: scl_w, sda: sda_w};
    // clock
    always #2.5 clk = ~clk;
    twm_master u_dut (.clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .line_in(line_in),
        .line_out(line_out), .line_oe(line_oe), .irq(irq));
    twm_slave_model #(.MY_ADDR(7'h50)) u_slave (.clk(clk), .scl(scl_w), .sda(sda_w), .stretch(stretch),
        .tx_byte(8'h3c), .scl_oe(slv_scl), .sda_oe(slv_sda), .rx_byte(rx_byte), .last_ack(last_ack),
        .n_bytes(n_bytes), .n_stops(n_stops));
    // ==========================================
    // tasks
    task automatic conclude();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do @(posedge clk); while (waitrequest !== 1'b0);
        r = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] s;
        acc(1'b0, a, 32'h0, s);
        chk(s, e);
    endtask
    task automatic poll(input logic [31:0] m, input logic [31:0] w);
        logic [31:0] s;
        int i;
        i = 0;
        do begin
            acc(1'b0, OFS_STAT, 32'h0, s);
            i++;
        end while ((s & m) !== w && i < 3000);
        chk(s & m, w);
    endtask
    task automatic wait_bytes(input int k);
        int i;
        for (i = 0; i < 20000 && n_bytes < k; i++) @(posedge clk);
    endtask
    task automatic stop_wait(input logic [31:0] ctl, input logic [31:0] w1c);
        logic [31:0] s;
        acc(1'b1, OFS_CTRL, ctl | K_STOP, s);
        acc(1'b1, OFS_STAT, w1c, s);
        poll(S_OWN, 32'h0);
        acc(1'b0, OFS_STAT, 32'h0, s);
        chk(s & S_BUSY, S_BUSY);
        poll(S_BUSY, 32'h0);
    endtask
    // ==========================================
    // tests
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        rdchk(OFS_DIV, 32'(DIV_RST));
        rdchk(OFS_STAT, 32'h0);
        rdchk(4'h2, 32'h0);
        acc(1'b1, OFS_DIV, 32'h8, q);
        rdchk(OFS_DIV, 32'h8);
        // another device already holds the clock low
        other_scl <= 1'b1;
        acc(1'b1, OFS_CTRL, K_START | K_IRQ, q);
        poll(S_ERR | S_OWN, S_ERR);
        chk(32'(irq), 32'h1);
        other_scl <= 1'b0;
        acc(1'b1, OFS_STAT, S_ERR | S_BUSY, q);
        // address write to a present slave
        acc(1'b1, OFS_CTRL, K_START | K_IRQ, q);
        poll(S_ERR | S_DSR | S_OWN, S_DSR | S_OWN);
        chk(32'(irq), 32'h1);
        acc(1'b1, OFS_DATA, 32'ha0, q);
        poll(S_DSR | S_REF | S_OWN, S_DSR | S_OWN);
        chk(32'(rx_byte), 32'ha0);
        stop_wait(K_IRQ, 32'h0);
        chk(n_stops, 32'h1);
        // address nobody answers
        acc(1'b1, OFS_CTRL, K_START, q);
        poll(S_OWN | S_DSR, S_OWN | S_DSR);
        acc(1'b1, OFS_DATA, 32'hb4, q);
        poll(S_REF | S_DSR, S_REF);
        chk(32'(irq), 32'h0);
        stop_wait(32'h0, S_REF);
        // broadcast call to all slaves
        acc(1'b1, OFS_CTRL, K_START, q);
        poll(S_OWN | S_DSR, S_OWN | S_DSR);
        acc(1'b1, OFS_DATA, 32'h00, q);
        poll(S_DSR | S_REF | S_OWN, S_DSR | S_OWN);
        stop_wait(32'h0, 32'h0);
        // read with a stretching slave, last byte refused
        stretch <= 8'd20;
        acc(1'b1, OFS_CTRL, K_START | K_NACK, q);
        poll(S_OWN | S_DSR, S_OWN | S_DSR);
        acc(1'b1, OFS_DATA, 32'ha1, q);
        wait_bytes(2);
        poll(S_DSR | S_REF, S_DSR);
        chk(32'(last_ack), 32'h1);
        stop_wait(32'h0, 32'h0);
        rdchk(OFS_DATA, 32'h3c);
        // stall after start
        stretch <= 8'd0;
        acc(1'b1, OFS_CTRL, K_START | K_SAS | K_IRQ, q);
        poll(S_OWN | S_DSR, S_OWN | S_DSR);
        acc(1'b1, OFS_DATA, 32'ha0, q);
        poll(S_SAS | S_DSR | S_REF, S_SAS);
        chk(32'(irq), 32'h1);
        repeat (40) @(posedge clk);
        chk(32'(scl_w), 32'h0);
        stop_wait(32'h0, S_SAS);
        // another master wins the address phase
        acc(1'b1, OFS_CTRL, K_START, q);
        poll(S_OWN | S_DSR, S_OWN | S_DSR);
        other_sda <= 1'b1;
        acc(1'b1, OFS_DATA, 32'ha0, q);
        poll(S_ERR | S_OWN, S_ERR);
        chk(32'(line_oe), 32'h0);
        chk(32'(line_out), 32'h0);
        other_sda <= 1'b0;
        acc(1'b1, OFS_STAT, S_ERR, q);
        poll(S_BUSY, 32'h0);
        conclude();
    end
    // watchdog against a hang
    initial begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        conclude();
    end
endmodule
